// ==== power_mode_reset_sequencer.v ====
// Power-mode sequencer, reset collector and register slave
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_defs.vh"

module power_mode_reset_sequencer (
    // Clock, power-on reset, clock enable
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        ce,
    // Avalon-MM slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Reset pin and wake sources
    input  wire        external_reset_pin_n,
    input  wire        pin_interrupt_unit,
    input  wire        rtcIrq,
    input  wire        low_voltage_detector,
    input  wire        periphIrq,
    // Supply monitors
    input  wire        supplyFault,
    input  wire        supplyWarn,
    // CPU
    input  wire        cpuHaltReq,
    // Boost
    input  wire        extLfClk,
    input  wire        boostBelowTarget,
    // Mode and gating outputs
    output reg  [2:0]  powerMode,
    output reg  [7:0]  subsysClkEn,
    output reg         retainHold,
    output reg         monitorEn,
    // Interrupt and reset outputs
    output reg         central_timewheel,
    output reg         supplyIrq,
    output reg         sysResetN,
    // Boost outputs
    output reg  [1:0]  boostFreqSel,
    output reg         boostUseXtal,
    output reg         boostStandby,
    output reg         boostPulse
);

    // Mode states
    localparam [2:0] ST_ACTIVE = 3'h0;
    localparam [2:0] ST_ALT    = 3'h1;
    localparam [2:0] ST_SLEEP  = 3'h2;
    localparam [2:0] ST_HIB    = 3'h3;
    localparam [2:0] ST_RESUME = 3'h4;

    reg  [2:0]  mode, next_mode;
    reg  [9:0]  resumeCnt, next_resumeCnt;
    reg  [7:0]  actTpl, altTpl, buzzCnt;
    reg  [3:0]  wakeEn, boostCfg;
    reg  [15:0] ctwPeriod, ctwCnt, wdtPeriod;
    reg  [4:0]  rstStatus, rstCnt;
    reg  [31:0] rdMux;
    reg         swRstDis, cpuOff, cpuForce, warnPend;
    reg         lfPrev, extPrev, ack, ctwTick;

    wire        wdtArmed, wdtBite, wrStrobe, extHeld, sysRst, swRstReq;
    wire        supplyRst, warnSeen, sleepWake, runWake, monOn;

    // Template gating with the CPU bit replaced by its live state
    function [7:0] gateTpl;
        input [7:0] tpl;
        input       cpu;
        begin
            gateTpl = {tpl[7:1], cpu};
        end
    endfunction

    // Bus handshake: one wait cycle, then the answer
    assign avs_waitrequest = (avs_read | avs_write) & ~(ack & ce);
    assign wrStrobe        = avs_write & ack;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else if (ce) begin
            ack <= (avs_read | avs_write) & ~ack;
            if (avs_read && !ack)
                avs_readdata <= rdMux;
        end
    end

    // Read decode; unmapped offsets read zero
    always @* begin
        case (avs_address)
            `REG_MODE_CTRL:   rdMux = {29'h0, mode};
            `REG_ACT_TPL:     rdMux = {24'h0, actTpl};
            `REG_ALT_TPL:     rdMux = {24'h0, altTpl};
            `REG_WAKE_EN:     rdMux = {28'h0, wakeEn};
            `REG_CTW_PERIOD:  rdMux = {16'h0, ctwPeriod};
            `REG_BOOST_CFG:   rdMux = {28'h0, boostCfg};
            `REG_WDT_CTRL:    rdMux = {15'h0, wdtArmed, wdtPeriod};
            `REG_SW_RESET:    rdMux = {30'h0, swRstDis, 1'b0};
            `REG_RST_STATUS:  rdMux = {27'h0, rstStatus};
            `REG_MODE_STATUS: rdMux = {21'h0, subsysClkEn, powerMode};
            default:          rdMux = 32'h00000000;
        endcase
    end

    // Reset sources
    assign extHeld   = ~external_reset_pin_n;
    assign swRstReq  = wrStrobe && avs_address == `REG_SW_RESET
                       && avs_writedata[`SWR_REQ_BIT] && !swRstDis;
    assign monOn     = mode == ST_ACTIVE || mode == ST_ALT || mode == ST_RESUME
                       || (mode == ST_SLEEP && buzzCnt == 8'h00);
    assign supplyRst = monOn & supplyFault;
    assign warnSeen  = monOn & supplyWarn;
    assign sysRst    = extHeld | (rstCnt != 5'h00);

    // Reset pulse stretcher; a new cause restarts it
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstCnt    <= 5'h00;
            sysResetN <= 1'b0;
        end else if (ce) begin
            if (wdtBite || swRstReq || supplyRst)
                rstCnt <= `SYSRST_CYC;
            else if (rstCnt != 5'h00)
                rstCnt <= rstCnt - 5'h01;
            sysResetN <= ~(extHeld | wdtBite | swRstReq | supplyRst
                           | (rstCnt > 5'h01));
        end
    end

    // Latest cause, one bit each, survives system reset
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rstStatus <= 5'h00;
            extPrev   <= 1'b0;
        end else if (ce) begin
            extPrev <= extHeld;
            if (extHeld && !extPrev)
                rstStatus <= 5'h01 << `RST_EXT_BIT;
            else if (wdtBite)
                rstStatus <= 5'h01 << `RST_WDT_BIT;
            else if (swRstReq)
                rstStatus <= 5'h01 << `RST_SW_BIT;
            else if (supplyRst)
                rstStatus <= 5'h01 << `RST_SUPPLY_BIT;
            else if (warnSeen && !warnPend)
                rstStatus <= 5'h01 << `RST_WARN_BIT;
        end
    end

    // Firmware-written configuration, cleared by any system reset
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            actTpl    <= `ACT_TPL_RST;
            altTpl    <= `ALT_TPL_RST;
            wakeEn    <= `WAKE_EN_RST;
            ctwPeriod <= `CTW_PERIOD_RST;
            boostCfg  <= `BOOST_CFG_RST;
            wdtPeriod <= `WDT_PERIOD_RST;
            swRstDis  <= 1'b0;
        end else if (ce) begin
            if (sysRst) begin
                actTpl    <= `ACT_TPL_RST;
                altTpl    <= `ALT_TPL_RST;
                wakeEn    <= `WAKE_EN_RST;
                ctwPeriod <= `CTW_PERIOD_RST;
                boostCfg  <= `BOOST_CFG_RST;
                wdtPeriod <= `WDT_PERIOD_RST;
                swRstDis  <= 1'b0;
            end else if (wrStrobe) begin
                case (avs_address)
                    `REG_ACT_TPL:    actTpl    <= avs_writedata[7:0];
                    `REG_ALT_TPL:    altTpl    <= avs_writedata[7:0];
                    `REG_WAKE_EN:    wakeEn    <= avs_writedata[3:0];
                    `REG_CTW_PERIOD: ctwPeriod <= avs_writedata[15:0];
                    `REG_BOOST_CFG:  boostCfg  <= avs_writedata[3:0];
                    `REG_WDT_CTRL:   wdtPeriod <= avs_writedata[15:0];
                    `REG_SW_RESET:   swRstDis  <= avs_writedata[`SWR_DIS_BIT];
                    default:         swRstDis  <= swRstDis;
                endcase
            end
        end
    end

    // Watchdog; firmware should not arm it before low-power entry
    watchdog_counter u_wdt (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .ce      (ce),
        .armReq  (wrStrobe && avs_address == `REG_WDT_CTRL
                  && avs_writedata[`WDT_EN_BIT]),
        .kick    (sysRst || (wrStrobe && avs_address == `REG_WDT_KICK)),
        .period  (wdtPeriod),
        .armed   (wdtArmed),
        .bite    (wdtBite)
    );

    // Timewheel and sleep buzz timers; both stop in hibernate
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctwCnt  <= 16'h0000;
            ctwTick <= 1'b0;
            buzzCnt <= 8'h00;
        end else if (ce) begin
            ctwTick <= 1'b0;
            if (sysRst || mode == ST_HIB || ctwPeriod == 16'h0000) begin
                ctwCnt <= 16'h0000;
            end else if (ctwCnt >= ctwPeriod) begin
                ctwCnt  <= 16'h0000;
                ctwTick <= 1'b1;
            end else begin
                ctwCnt <= ctwCnt + 16'h0001;
            end
            if (mode == ST_SLEEP)
                buzzCnt <= buzzCnt + 8'h01;
            else
                buzzCnt <= 8'h00;
        end
    end

    // Wake qualification per mode
    assign sleepWake = |(wakeEn & {low_voltage_detector | warnSeen, ctwTick,
                                   rtcIrq, pin_interrupt_unit});
    assign runWake   = periphIrq | warnSeen | ctwTick | pin_interrupt_unit
                       | rtcIrq | low_voltage_detector;

    // Mode transitions
    always @* begin
        next_mode      = mode;
        next_resumeCnt = resumeCnt;
        case (mode)
            ST_ACTIVE, ST_ALT: begin
                if (mode == ST_ALT && runWake) begin
                    next_mode = ST_ACTIVE;
                end else if (wrStrobe && avs_address == `REG_MODE_CTRL) begin
                    case (avs_writedata[1:0])
                        `MODE_ALT:   next_mode = ST_ALT;
                        `MODE_SLEEP: next_mode = ST_SLEEP;
                        `MODE_HIB:   next_mode = ST_HIB;
                        default:     next_mode = ST_ACTIVE;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (sleepWake) begin
                    next_mode      = ST_RESUME;
                    next_resumeCnt = `SLEEP_RESUME_CYC;
                end
            end
            ST_HIB: begin
                if (pin_interrupt_unit) begin
                    next_mode      = ST_RESUME;
                    next_resumeCnt = `HIB_RESUME_CYC;
                end
            end
            ST_RESUME: begin
                next_resumeCnt = resumeCnt - 10'h001;
                if (resumeCnt <= 10'h001)
                    next_mode = ST_ACTIVE;
            end
            default: begin
                next_mode = ST_ACTIVE;
            end
        endcase
    end

    // Mode state; resets return the device to active
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode      <= ST_ACTIVE;
            resumeCnt <= 10'h000;
        end else if (ce) begin
            if (sysRst) begin
                mode      <= ST_ACTIVE;
                resumeCnt <= 10'h000;
            end else begin
                mode      <= next_mode;
                resumeCnt <= next_resumeCnt;
            end
        end
    end

    // CPU self-halt and forced enable; a wake in the same cycle wins
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cpuOff   <= 1'b0;
            cpuForce <= 1'b0;
        end else if (ce) begin
            if (sysRst) begin
                cpuOff   <= 1'b0;
                cpuForce <= 1'b0;
            end else if ((mode == ST_RESUME && next_mode == ST_ACTIVE)
                         || ((mode == ST_ACTIVE || mode == ST_ALT) && runWake)) begin
                cpuOff   <= 1'b0;
                cpuForce <= 1'b1;
            end else begin
                if (cpuHaltReq && (mode == ST_ACTIVE || mode == ST_ALT))
                    cpuOff <= 1'b1;
                if (wrStrobe && avs_address == `REG_ACT_TPL)
                    cpuForce <= 1'b0;
            end
        end
    end

    // Supply warning raised during sleep waits until active
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            warnPend  <= 1'b0;
            supplyIrq <= 1'b0;
        end else if (ce) begin
            if (sysRst)
                warnPend <= 1'b0;
            else if (warnSeen)
                warnPend <= 1'b1;
            else if (wrStrobe && avs_address == `REG_RST_STATUS)
                warnPend <= 1'b0;
            supplyIrq <= warnPend && !sysRst
                         && (mode == ST_ACTIVE || mode == ST_ALT);
        end
    end

    // Registered mode, gating and boost outputs
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            powerMode         <= ST_ACTIVE;
            subsysClkEn       <= 8'h00;
            retainHold        <= 1'b0;
            monitorEn         <= 1'b0;
            central_timewheel <= 1'b0;
            boostFreqSel      <= 2'h0;
            boostUseXtal      <= 1'b0;
            boostStandby      <= 1'b0;
            boostPulse        <= 1'b0;
            lfPrev            <= 1'b0;
        end else if (ce) begin
            powerMode         <= mode;
            retainHold        <= mode == ST_HIB;
            monitorEn         <= monOn;
            central_timewheel <= ctwTick;
            lfPrev            <= extLfClk;
            if (sysRst)
                subsysClkEn <= 8'h00;
            else if (mode == ST_ACTIVE)
                subsysClkEn <= gateTpl(actTpl, (actTpl[0] | cpuForce) & ~cpuOff);
            else if (mode == ST_ALT)
                subsysClkEn <= gateTpl(altTpl, (altTpl[0] | cpuForce) & ~cpuOff);
            else
                subsysClkEn <= 8'h00;
            boostFreqSel <= boostCfg[1:0];
            boostUseXtal <= boostCfg[1:0] == `BOOST_SEL_32K;
            boostStandby <= boostCfg[`BOOST_STBY_BIT] && mode != ST_HIB;
            boostPulse   <= boostCfg[`BOOST_STBY_BIT] && boostCfg[`BOOST_AUTO_BIT]
                            && mode != ST_HIB && boostBelowTarget
                            && (extLfClk != lfPrev);
        end
    end

endmodule // power_mode_reset_sequencer
`default_nettype wire

// ==== pmrs_defs.vh ====
// Offsets, fields, reset values and timing constants of the power-mode and reset sequencer
// How it works
// - Active template bits enable each subsystem
// - Disabled subsystem has its clocks gated
// - CPU may halt itself; next wakeup restarts it
// - Wakeup forces active mode and CPU enable
// - Device starts in active mode after boot
// - Sleep exit waits 15 us resume interval
// - Hibernate keeps state and holds output pins
// - Hibernate exit by pin interrupt, under 100 us
// - Interrupts and pin or watchdog resets wake
// - Timewheel gives periodic wakeup interrupts
// - Boost switching clock has four settings
// - Slowest boost setting uses external crystal
// - Auto pulse on both crystal edges when low
// - Boost mode limited by chip power mode
// - Supply out of range forces a reset
// - Supply monitors can interrupt before reset
// - Reset pin low holds the device in reset
// - Unrefreshed watchdog generates a reset
// - Firmware can command a reset
// - System reset clears processor, peripherals, registers
// - Status records latest cause, cleared by power-on
// - Sleep supply interrupt served after wakeup sequence
// - A register bit disables software reset
// - Watchdog enable sticky until power-on reset
// - Sleep wakes only from pin, clock, timewheel, detector; the code also wakes it on a supply warning, under the detector enable bit
`ifndef PMRS_DEFS_VH
`define PMRS_DEFS_VH

// Register byte offsets
`define REG_MODE_CTRL    6'h00
`define REG_ACT_TPL      6'h04
`define REG_ALT_TPL      6'h08
`define REG_WAKE_EN      6'h0c
`define REG_CTW_PERIOD   6'h10
`define REG_BOOST_CFG    6'h14
`define REG_WDT_CTRL     6'h18
`define REG_WDT_KICK     6'h1c
`define REG_SW_RESET     6'h20
`define REG_RST_STATUS   6'h24
`define REG_MODE_STATUS  6'h28

// Mode request codes written to the mode control register
`define MODE_ACTIVE      2'h0
`define MODE_ALT         2'h1
`define MODE_SLEEP       2'h2
`define MODE_HIB         2'h3

// Reset values
`define ACT_TPL_RST      8'hff
`define ALT_TPL_RST      8'hfe
`define WAKE_EN_RST      4'hf
`define CTW_PERIOD_RST   16'h0000
`define BOOST_CFG_RST    4'h0
`define WDT_PERIOD_RST   16'hffff

// Field positions
`define SWR_REQ_BIT      0
`define SWR_DIS_BIT      1
`define WDT_EN_BIT       16
`define BOOST_STBY_BIT   2
`define BOOST_AUTO_BIT   3
`define BOOST_SEL_32K    2'h3

// Reset status bits
`define RST_EXT_BIT      0
`define RST_WDT_BIT      1
`define RST_SW_BIT       2
`define RST_SUPPLY_BIT   3
`define RST_WARN_BIT     4

// Timing
`define CLK_MHZ          10'h00a
`define SLEEP_RESUME_US  10'h00f
`define HIB_RESUME_US    10'h064
`define SLEEP_RESUME_CYC (`SLEEP_RESUME_US * `CLK_MHZ)
`define HIB_RESUME_CYC   (`HIB_RESUME_US * `CLK_MHZ - 10'h001)
`define SYSRST_CYC       5'h10
`define BUZZ_CYC         256
`define WDT_PRESCALE     256

`endif

// ==== watchdog_counter.v ====
// Watchdog counter with sticky enable and firmware refresh
`timescale 1ns/1ps
`default_nettype none
`include "pmrs_defs.vh"

module watchdog_counter (
    // Clock, reset, enable
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        ce,
    // Control
    input  wire        armReq,
    input  wire        kick,
    input  wire [15:0] period,
    // Status
    output reg         armed,
    output reg         bite
);

    localparam [31:0] PRE_LAST = `WDT_PRESCALE - 32'h1;

    reg [7:0]  preCnt;
    reg [15:0] ticks;

    // Enable survives system reset; only power-on clears it
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            armed  <= 1'b0;
            preCnt <= 8'h00;
            ticks  <= 16'h0000;
            bite   <= 1'b0;
        end else if (ce) begin
            bite <= 1'b0;
            if (armReq)
                armed <= 1'b1;
            if (!armed || kick) begin
                preCnt <= 8'h00;
                ticks  <= 16'h0000;
            end else begin
                preCnt <= preCnt + 8'h01;
                if (preCnt == PRE_LAST[7:0]) begin
                    if (ticks >= period) begin
                        bite  <= 1'b1;
                        ticks <= 16'h0000;
                    end else begin
                        ticks <= ticks + 16'h0001;
                    end
                end
            end
        end
    end

endmodule // watchdog_counter
`default_nettype wire

// ==== pmrs_props.sv ====
// Port-level assertions for the power-mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module pmrs_props (
    // Clock, reset, enable
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       ce,
    // Inputs watched
    input wire logic       external_reset_pin_n,
    input wire logic       boostBelowTarget,
    // Outputs watched
    input wire logic [2:0] powerMode,
    input wire logic [7:0] subsysClkEn,
    input wire logic       retainHold,
    input wire logic       central_timewheel,
    input wire logic       sysResetN,
    input wire logic [1:0] boostFreqSel,
    input wire logic       boostUseXtal,
    input wire logic       boostStandby,
    input wire logic       boostPulse
);
    // Low enable freezes all state, so nothing is judged then
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn || !ce);

    property p_gateSleep;
        powerMode == 3'h2 && $past(powerMode) == 3'h2 |-> subsysClkEn == 8'h00;
    endproperty
    a_gateSleep: assert property (p_gateSleep) else $error("clocks run in sleep");
    property p_hibHold;
        powerMode == 3'h3 && $past(powerMode) == 3'h3 |-> retainHold && !boostStandby;
    endproperty
    a_hibHold: assert property (p_hibHold) else $error("hold or standby wrong in hibernate");
    property p_xtalSel;
        boostUseXtal == (boostFreqSel == 2'h3);
    endproperty
    a_xtalSel: assert property (p_xtalSel) else $error("crystal select mismatch");
    property p_pulseCause;
        boostPulse |-> powerMode != 3'h3 && $past(boostBelowTarget);
    endproperty
    a_pulseCause: assert property (p_pulseCause) else $error("boost pulse without cause");
    property p_pinHold;
        !external_reset_pin_n [*3] |-> !sysResetN;
    endproperty
    a_pinHold: assert property (p_pinHold) else $error("pin low but no reset");
    property p_rstGate;
        !sysResetN && !$past(sysResetN) |-> subsysClkEn == 8'h00;
    endproperty
    a_rstGate: assert property (p_rstGate) else $error("clocks run in reset");
    property p_rstMode;
        $rose(sysResetN) |-> powerMode == 3'h0;
    endproperty
    a_rstMode: assert property (p_rstMode) else $error("not active after reset");
    property p_tickPulse;
        central_timewheel |=> !central_timewheel;
    endproperty
    a_tickPulse: assert property (p_tickPulse) else $error("timewheel tick too long");
endmodule // pmrs_props

bind power_mode_reset_sequencer pmrs_props u_pmrs_props (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .external_reset_pin_n(external_reset_pin_n),
    .boostBelowTarget(boostBelowTarget), .powerMode(powerMode), .subsysClkEn(subsysClkEn),
    .retainHold(retainHold), .central_timewheel(central_timewheel), .sysResetN(sysResetN),
    .boostFreqSel(boostFreqSel), .boostUseXtal(boostUseXtal), .boostStandby(boostStandby),
    .boostPulse(boostPulse));
`default_nettype wire

// ==== pmrs_partner.sv ====
// Far-side model: reset pin with pull-up and free 32 kHz crystal
`timescale 1ns/1ps
`default_nettype none
module pmrs_partner (
    // Request from the bench
    input wire logic  pullLow,
    // Pins
    output wire logic external_reset_pin_n,
    output var logic  extLfClk
);
    // Pull-up keeps the pin inactive unless pulled
    assign external_reset_pin_n = pullLow ? 1'b0 : 1'b1;
    // Crystal runs free, unrelated in phase to the system clock
    initial extLfClk = 1'b0;
    always #15625 extLfClk = ~extLfClk;
endmodule // pmrs_partner
`default_nettype wire

// ==== power_mode_reset_sequencer_tb.sv ====
// Self-checking bench for the power-mode and reset sequencer
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_sequencer_tb;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    logic        pullLow = 1'b0;
    logic        below = 1'b0;
    logic [6:0]  ev = 7'h00;
    wire         pinN, lfClk, retainHold, tick, supplyIrq, sysResetN, useXtal, standby, boostPulse, monEn;
    wire  [2:0]  powerMode;
    wire  [7:0]  subsysClkEn;
    wire  [1:0]  freqSel;
    int          num_errors = 0;
    int          checks = 0;
    int          n, k;
    logic [31:0] q;
    // Reset values of eight readable registers (not 0x00 or 0x20), plus one unmapped place
    logic [5:0]  ra[9] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h24, 6'h28, 6'h3c};
    logic [31:0] rv[9] = '{32'hff, 32'hfe, 32'hf, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h7f8, 32'h0};

    always #50 ref_clk = ~ref_clk;

    pmrs_partner u_pmrs_partner (.pullLow(pullLow), .external_reset_pin_n(pinN), .extLfClk(lfClk));

    // Event bits: 0 pin irq, 1 rtc, 2 detector, 3 periph, 4 fault, 5 warn, 6 halt
    power_mode_reset_sequencer u_power_mode_reset_sequencer (
        .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .external_reset_pin_n(pinN), .pin_interrupt_unit(ev[0]),
        .rtcIrq(ev[1]), .low_voltage_detector(ev[2]), .periphIrq(ev[3]), .supplyFault(ev[4]),
        .supplyWarn(ev[5]), .cpuHaltReq(ev[6]), .extLfClk(lfClk), .boostBelowTarget(below),
        .powerMode(powerMode), .subsysClkEn(subsysClkEn), .retainHold(retainHold), .monitorEn(monEn),
        .central_timewheel(tick), .supplyIrq(supplyIrq), .sysResetN(sysResetN),
        .boostFreqSel(freqSel), .boostUseXtal(useXtal), .boostStandby(standby), .boostPulse(boostPulse));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q, exp);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge ref_clk);
    endtask

    // One-cycle pulse on an event input
    task automatic pulse(input int b);
        @(posedge ref_clk);
        ev[b] <= 1'b1;
        @(posedge ref_clk);
        ev[b] <= 1'b0;
    endtask

    task automatic waitRst(input logic v);
        for (n = 0; sysResetN !== v; n++) @(posedge ref_clk);
    endtask

    task automatic waitMode(input logic [2:0] m);
        for (n = 0; powerMode !== m; n++) @(posedge ref_clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watchdog: the tests need a few thousand cycles at most
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end

    initial begin
        cyc(20);
        resetn <= 1'b1;
        cyc(2);
        chk("mode", powerMode, 3'h0);
        chk("monEn", monEn, 1);
        for (int i = 0; i < 9; i++) rdc(ra[i], rv[i]);
        wr(6'h04, 32'h5a);
        cyc(2);
        chk("clkEn", subsysClkEn, 8'h5a);
        wr(6'h04, 32'hff);
        pulse(6);
        cyc(2);
        chk("clkEn", subsysClkEn, 8'hfe);
        wr(6'h00, 32'h2);
        cyc(3);
        chk("clkEn", subsysClkEn, 8'h00);
        pulse(3);
        cyc(5);
        chk("mode", powerMode, 3'h2);
        chk("monEn", monEn, 0);
        pulse(0);
        waitMode(3'h0);
        chk("resume", n >= 149 && n <= 153, 1);
        cyc(1);
        chk("clkEn", subsysClkEn, 8'hff);
        wr(6'h04, 32'hff);
        wr(6'h08, 32'h0c);
        wr(6'h00, 32'h1);
        cyc(3);
        chk("clkEn", subsysClkEn, 8'h0c);
        pulse(3);
        cyc(3);
        chk("mode", powerMode, 3'h0);
        wr(6'h10, 32'h9);
        while (tick !== 1'b1) @(posedge ref_clk);
        k = 0;
        do begin @(posedge ref_clk); k++; end while (tick !== 1'b1);
        chk("tick", k, 10);
        wr(6'h10, 32'h0);
        for (int s = 0; s < 4; s++) begin
            wr(6'h14, s);
            cyc(2);
            chk("sel", freqSel, s);
            chk("xtal", useXtal, s == 3);
        end
        wr(6'h14, 32'hf);
        below <= 1'b1;
        k = 0;
        repeat (700) begin @(posedge ref_clk); if (boostPulse === 1'b1) k++; end
        chk("pulses", k >= 4 && k <= 5, 1);
        wr(6'h04, 32'hfe);
        wr(6'h00, 32'h3);
        cyc(3);
        chk("hold", retainHold, 1);
        chk("stby", standby, 0);
        pulse(1);
        pulse(3);
        cyc(5);
        chk("mode", powerMode, 3'h3);
        pulse(0);
        waitMode(3'h0);
        chk("hibWake", n - 2 < 1000, 1);
        cyc(1);
        chk("clkEn", subsysClkEn, 8'hff);
        rdc(6'h14, 32'hf);
        wr(6'h20, 32'h1);
        waitRst(1'b0);
        waitRst(1'b1);
        chk("swLen", n, 16);
        rdc(6'h24, 32'h4);
        rdc(6'h04, 32'hff);
        wr(6'h20, 32'h2);
        wr(6'h20, 32'h3);
        k = 0;
        repeat (20) begin @(posedge ref_clk); if (sysResetN !== 1'b1) k++; end
        chk("swOff", k, 0);
        pullLow <= 1'b1;
        cyc(10);
        chk("pinRst", sysResetN, 0);
        pullLow <= 1'b0;
        waitRst(1'b1);
        rdc(6'h24, 32'h1);
        rdc(6'h20, 32'h0);
        pulse(5);
        cyc(3);
        chk("warnIrq", supplyIrq, 1);
        rdc(6'h24, 32'h10);
        wr(6'h24, 32'h0);
        cyc(2);
        chk("warnIrq", supplyIrq, 0);
        pulse(4);
        waitRst(1'b0);
        waitRst(1'b1);
        rdc(6'h24, 32'h8);
        wr(6'h18, 32'h10000);
        waitRst(1'b0);
        chk("bite", n >= 250 && n <= 262, 1);
        waitRst(1'b1);
        rdc(6'h24, 32'h2);
        rdc(6'h18, 32'h1ffff);
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        cyc(2);
        rdc(6'h24, 32'h0);
        rdc(6'h18, 32'hffff);
        give_verdict();
    end
endmodule // power_mode_reset_sequencer_tb
`default_nettype wire
